// [bench/scp_line_master.sv]
`timescale 1ns/1ps
`default_nettype none
module scp_line_master (
    output logic serialClk,
    output logic frameSync,
    output logic commandInput,
    input wire logic statusOut,
    input wire logic statusOutEn,
    output logic lineLevel,
    output logic [7:0] rxByte,
    output logic rxDone
);
    // Poll gap scaled down with the settle count to keep the run short
    localparam realtime POLL_NS = 2000.0;
    realtime lastPoll [8];
    // Pull-up holds the line high while nobody pulls it
    assign lineLevel = statusOutEn ? statusOut : 1'b1;
    initial
    begin
        foreach (lastPoll[i])
            lastPoll[i] = -POLL_NS;
        serialClk = 1'b0;
        frameSync = 1'b0;
        commandInput = 1'b0;
        rxByte = 8'h00;
        rxDone = 1'b0;
    end
    task automatic send(input logic [15:0] w, input int nb);
        logic [7:0] b;
        b = 8'hff;
        if (w[15])
        begin
            if ($realtime - lastPoll[w[14:12]] < POLL_NS)
                #(POLL_NS - ($realtime - lastPoll[w[14:12]]));
            lastPoll[w[14:12]] = $realtime;
        end
        serialClk = 1'b1;
        frameSync = 1'b1;
        #62.5 serialClk = 1'b0;
        #62.5;
        for (int i = 15; i > 15 - nb; i--)
        begin
            // Status bit sampled half a clock after the device launches it
            if (i <= 7)
            begin
                b[i] = lineLevel;
            end
            serialClk = 1'b1;
            frameSync = 1'b0;
            commandInput = w[i];
            #62.5 serialClk = 1'b0;
            #62.5;
        end
        // Idle data shows the inverse, never a stale copy
        commandInput = ~w[16 - nb];
        rxByte = b;
        rxDone = w[15] && (nb == 16);
        #1 rxDone = 1'b0;
    endtask : send
endmodule : scp_line_master
`default_nettype wire

// [bench/tb_serial_channel_command_port.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_serial_channel_command_port;
    import scp_pkg::*;
    localparam logic [3:0] DEV = 4'h5; // Arbitrary device code
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic serialClk, frameSync, commandInput, lineLevel, statusOut, statusOutEn;
    logic bankSelectInput = 1'b0;
    logic [3:0] chanInReg = 4'hf;
    logic [3:0] dutyExtreme = 4'h0;
    logic [3:0] overCurrent = 4'h0;
    logic overTemp = 1'b0;
    logic [3:0] chanEnable, passThrough, avs_address = 4'h0;
    logic [15:0] chanCode;
    logic globalStart, initDone, rampStagger, avs_waitrequest, rxDone;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic [7:0] rxByte;
    logic [31:0] avQ[$];
    logic [7:0] statQ[$];
    logic [3:0] mEn = 4'h0;
    logic [15:0] mCode = 16'h0;
    logic mInit = 1'b0;
    logic mStag = 1'b0;
    int miscompares = 0;
    int samplesChecked = 0;
    int gsCnt = 0;
    always #5 ref_clk = ~ref_clk;
    scp_port #(.DEVICE_CODE(DEV), .SETTLE_CYCLES(16'h8)) dut (
        .ref_clk(ref_clk), .reset(reset), .serialClk(serialClk),
        .frameSync(frameSync), .commandInput(commandInput),
        .bankSelectInput(bankSelectInput), .statusOutIn(lineLevel),
        .statusOut(statusOut), .statusOutEn(statusOutEn),
        .chanInReg(chanInReg), .dutyExtreme(dutyExtreme),
        .overCurrent(overCurrent), .overTemp(overTemp),
        .chanEnable(chanEnable), .chanCode(chanCode),
        .passThrough(passThrough), .globalStart(globalStart),
        .initDone(initDone), .rampStagger(rampStagger),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    scp_line_master lc (
        .serialClk(serialClk), .frameSync(frameSync),
        .commandInput(commandInput), .statusOut(statusOut),
        .statusOutEn(statusOutEn), .lineLevel(lineLevel),
        .rxByte(rxByte), .rxDone(rxDone));
    task automatic report_and_stop();
        if (miscompares == 0 && samplesChecked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    task automatic bump(input logic ok, input logic [31:0] e,
        input logic [31:0] g);
        samplesChecked++;
        if (!ok)
        begin
            miscompares++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : bump
    task automatic cmpAv(input logic [31:0] e, input logic [31:0] g);
        bump(g === e, e, g);
    endtask : cmpAv
    task automatic cmpStat(input logic [7:0] e, input logic [7:0] g);
        bump(g === e, {24'h0, e}, {24'h0, g});
    endtask : cmpStat
    task automatic cmpPort(input logic [31:0] e, input logic [31:0] g);
        bump(g === e, e, g);
    endtask : cmpPort
    always @(posedge ref_clk)
    begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
            cmpAv(avQ.pop_front(), avs_readdata);
        if (globalStart === 1'b1)
            gsCnt++;
    end
    always @(posedge rxDone)
        cmpStat(statQ.pop_front(), rxByte);
    task automatic av(input logic wr, input logic [3:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0)
        begin
            n++;
            if (n > 50)
            begin
                miscompares++;
                report_and_stop();
            end
            @(posedge ref_clk);
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask : av
    task automatic chk_state();
        logic [3:0] p;
        for (int n = 0; n < 4; n++)
            p[n] = mEn[n] && (mCode[4*n+:4] == 4'hf);
        avQ.push_back({22'h0, mStag, mInit, p, mEn});
        av(1'b0, OFF_STATE, 32'h0);
        avQ.push_back({16'h0, mCode});
        av(1'b0, OFF_CODE, 32'h0);
        cmpPort({6'h0, mStag, mInit, p, mEn, mCode}, {6'h0, rampStagger,
            initDone, passThrough, chanEnable, chanCode});
    endtask : chk_state
    task automatic frame(input logic [15:0] w, input int nb);
        lc.send(w, nb);
        repeat (8) @(posedge ref_clk);
    endtask : frame
    function automatic logic [15:0] mk(input logic rd, input logic bk,
        input logic [1:0] c, input logic [3:0] d, input logic [7:0] x);
        mk = {rd, bk, c, d, x};
    endfunction : mk
    initial
    begin
        repeat (90000) @(posedge ref_clk);
        miscompares++;
        report_and_stop();
    end
    initial
    begin
        logic [1:0] c;
        logic [3:0] v, ir, du, oc;
        void'($urandom(90));
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk_state();
        avQ.push_back(32'h8);
        av(1'b0, OFF_FILT, 32'h0);
        avQ.push_back(32'h0);
        av(1'b0, 4'h6, 32'h0);
        av(1'b1, OFF_STATE, $urandom);
        repeat (4)
        begin
            c = 2'($urandom);
            v = 4'($urandom % 15);
            frame(mk(1'b0, 1'b0, c, DEV, {v, 4'h0}), 16);
            mEn[c] = 1'b1;
            mCode[4*c+:4] = v;
            chk_state();
        end
        frame(mk(1'b0, 1'b0, c, DEV, 8'hf0), 16);
        mCode[4*c+:4] = 4'hf;
        chk_state();
        frame(mk(1'b0, 1'b0, c, DEV, {mCode[4*c+:4], 4'h8}), 16);
        mEn[c] = 1'b0;
        chk_state();
        frame(mk(1'b0, 1'b0, c, 4'ha, 8'h30), 16);
        frame(mk(1'b0, 1'b1, c, DEV, 8'h30), 16);
        frame(mk(1'b0, 1'b0, c, DEV, 8'h30), 10);
        chk_state();
        v = 4'($urandom % 15);
        frame(mk(1'b0, 1'b0, 2'h0, DEV, {v, 4'h4}), 16);
        mEn = 4'hf;
        mCode = {4{v}};
        chk_state();
        cmpPort(32'h1, gsCnt);
        frame(mk(1'b0, 1'b0, 2'h2, DEV, {v, 4'h8}), 16);
        mEn[2] = 1'b0;
        for (int k = 0; k < 6; k++)
        begin
            c = (k == 0) ? 2'h0 : 2'($urandom);
            ir = (k == 0) ? 4'hf : 4'($urandom);
            du = (k == 0) ? 4'h0 : 4'($urandom);
            oc = (k == 0) ? 4'h0 : 4'($urandom);
            chanInReg <= ir;
            dutyExtreme <= du;
            overCurrent <= oc;
            overTemp <= (k == 5);
            repeat (4) @(posedge ref_clk);
            statQ.push_back({k == 5, oc[c], du[c], ~mEn[c], 1'b0, ~ir[c],
                2'b00});
            frame(mk(1'b1, 1'b0, c, DEV, 8'($urandom)), 16);
        end
        chanInReg <= 4'hf;
        dutyExtreme <= 4'h0;
        overCurrent <= 4'h0;
        overTemp <= 1'b0;
        c = 2'($urandom);
        bankSelectInput <= c[0];
        statQ.push_back(8'hff);
        frame(mk(1'b1, ~c[0], 2'h0, DEV, 8'h00), 16);
        statQ.push_back(8'h00);
        frame(mk(1'b1, c[0], 2'h0, DEV, 8'h00), 16);
        bankSelectInput <= 1'b0;
        // Lane 1 only: lane 0 keeps the old count of 8
        avs_byteenable <= {2'($urandom), 2'b10};
        av(1'b1, OFF_FILT, {16'($urandom), 8'h10, 8'($urandom)});
        avQ.push_back(32'h1008);
        av(1'b0, OFF_FILT, 32'h0);
        frame(mk(1'b0, 1'b0, 2'h0, DEV, 8'h30), 16);
        mCode[3:0] = 4'h3;
        statQ.push_back(8'h08);
        frame(mk(1'b1, 1'b0, 2'h0, DEV, 8'h00), 16);
        repeat (4200) @(posedge ref_clk);
        statQ.push_back(8'h00);
        frame(mk(1'b1, 1'b0, 2'h0, DEV, 8'h00), 16);
        frame(mk(1'b0, 1'b0, 2'h1, DEV, 8'h09), 16);
        mEn[1] = 1'b0;
        chk_state();
        frame(mk(1'b0, 1'b0, 2'h0, DEV, 8'h21), 16);
        mEn = 4'h0;
        mCode = 16'h0;
        mInit = 1'b1;
        mStag = 1'b1;
        chk_state();
        frame(mk(1'b0, 1'b0, 2'h3, DEV, 8'h70), 16);
        mEn[3] = 1'b1;
        mCode[15:12] = 4'h7;
        frame(mk(1'b0, 1'b0, 2'h0, DEV, 8'h21), 16);
        // Locked init falls through to a plain code write on channel 0
        mEn[0] = 1'b1;
        mCode[3:0] = 4'h2;
        chk_state();
        report_and_stop();
    end
endmodule : tb_serial_channel_command_port
`default_nettype wire

// [verilog/scp_pkg.sv]
`default_nettype none
package scp_pkg;
    localparam int CLK_NS = 10;
    localparam int SETTLE_US = 250;
    localparam int SETTLE_CYC = SETTLE_US * 1000 / CLK_NS;
    localparam int WORD_BITS = 16;
    localparam int NCH = 4;
    localparam int BIT_RW = 15;
    localparam int BIT_BANK = 14;
    localparam int CH_LSB = 12;
    localparam int DSEL_LSB = 8;
    localparam int V_LSB = 4;
    localparam int D_SHUT = 3;
    localparam int D_GLOB = 2;
    localparam int D_INIT = 0;
    localparam int D_QUAL = 5;
    localparam logic [3:0] CODE_PASS = 4'hf;
    localparam logic [3:0] OFF_STATE = 4'h0;
    localparam logic [3:0] OFF_CODE = 4'h4;
    localparam logic [3:0] OFF_READY = 4'h8;
    localparam logic [3:0] OFF_FILT = 4'hc;
    localparam logic [15:0] RST_CODE = 16'h0000;
    localparam logic [3:0] RST_EN = 4'h0;

    typedef enum logic [2:0] {
        ST_WAIT = 3'b001,
        ST_SHIFT = 3'b010,
        ST_DONE = 3'b100
    } scp_state_t;

    typedef struct packed {
        scp_state_t st;
        logic sclkPrev;
        logic [4:0] bitCnt;
        logic [15:0] shreg;
        logic rdAct;
        logic [7:0] stat;
        logic odEn;
        logic odLvl;
        logic [3:0] en;
        logic [15:0] code;
        logic [3:0] pass;
        logic start;
        logic initDone;
        logic stagger;
        logic [3:0][15:0] settle;
        logic [3:0] ready;
        logic [15:0] filt;
        logic waitReq;
        logic [31:0] rdata;
    } scp_regs_t;

    // Header byte: device select and bank must both match
    function automatic logic addr_hit(input logic [7:0] hdr,
        input logic bank, input logic [3:0] dev);
        addr_hit = (hdr[3:0] == dev) && (hdr[6] == bank);
    endfunction : addr_hit
endpackage : scp_pkg
`default_nettype wire

// [verilog/scp_port.sv]
// How it works
// (RQ1) Frame sync and command input are taken on falling serial clock edges; frame sync is acted on as a level at every ref_clk edge.
// (RQ2) Master pulses frame sync before shifting each command word.
// (RQ3) While frame sync is high, bit and frame counters are held reset.
// (RQ4) First falling edge after sync takes bit 15; rest follow MSB first.
// (RQ5) Upper byte is address and command; lower byte is data.
// (RQ6) Read/write flag picks whether data is written or status returned.
// (RQ7) Only words whose bank bit equals the bank select input are served.
// (RQ8) Two channel select bits pick exactly one of four channels.
// (RQ9) Four-bit device select must equal the device code, else ignored.
// (RQ10) Write with data bit 3 set shuts down the addressed channel.
// (RQ11) Data bit 2 programs all outputs to the code and starts them together.
// (RQ12) Bit 0 with bit 5 initialises clocks once until full restart.
// (RQ13) Pass-through holds the channel switch fully on, no switching.
// (RQ14) Status read returns zero only when the channel is in regulation.
// (RQ15) Not ready: disabled, duty extreme, overcurrent, moving, or overtemp.
// (RQ16) Ready may lag settling by up to 250 us after a new target.
// (RQ17) Master polls a channel no more often than every 500 us.
// (RQ18) Word: rw, bank, channel[1:0], device select, code, shut, glob, -, init.
// (RQ19) Codes 0 to E give 7.5 V to 13.1 V in 0.4 V steps; F passes through.
// (RQ20) Initialise clears codes, disables outputs, staggers low-bank ramp.
// (RQ21) Status read is a read command with don't-care data byte.
// (RQ22) During read data half, status drives open drain MSB first.
// (RQ23) Mismatched words change nothing and leave the output released.
`timescale 1ns/1ps
`default_nettype none
module scp_port
    import scp_pkg::*;
#(
    parameter logic [3:0] DEVICE_CODE = 4'h5, // Arbitrary value
    parameter logic [15:0] SETTLE_CYCLES = 16'(scp_pkg::SETTLE_CYC)
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic serialClk,
    input wire logic frameSync,
    input wire logic commandInput,
    input wire logic bankSelectInput,
    input wire logic statusOutIn,
    output logic statusOut,
    output logic statusOutEn,
    input wire logic [scp_pkg::NCH-1:0] chanInReg,
    input wire logic [scp_pkg::NCH-1:0] dutyExtreme,
    input wire logic [scp_pkg::NCH-1:0] overCurrent,
    input wire logic overTemp,
    output logic [scp_pkg::NCH-1:0] chanEnable,
    output logic [15:0] chanCode,
    output logic [scp_pkg::NCH-1:0] passThrough,
    output logic globalStart,
    output logic initDone,
    output logic rampStagger,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    import scp_pkg::*;

    scp_regs_t r_r;
    scp_regs_t r_nxt;
    logic [3:0] syncQ;
    logic sclkS;
    logic fsS;
    logic dinS;
    logic bankS;
    logic fall;
    logic [15:0] word;
    logic hit8;
    logic hitW;
    logic wrExec;
    logic initNow;
    logic [1:0] wc;
    logic [7:0] d;

    if (SETTLE_CYCLES == 16'h0000)
    begin : g_bad_settle
        $error("scp_port: settle count must be nonzero");
    end

    scp_sync #(
        .W(4)
    ) u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .async({serialClk, frameSync, commandInput, bankSelectInput}),
        .stable(syncQ)
    );
    assign sclkS = syncQ[3];
    assign fsS = syncQ[2];
    assign dinS = syncQ[1];
    assign bankS = syncQ[0];

    // Nonzero while not settled; each cause has its own bit
    function automatic logic [7:0] chan_status(input scp_regs_t s,
        input logic [1:0] c, input logic inReg, input logic duty,
        input logic ovc, input logic ovt);
        chan_status = {ovt, ovc, duty, ~s.en[c], |s.settle[c], ~inReg,
            2'b00}; // [RQ15]
    endfunction : chan_status

    // Status byte goes out MSB first on the following edges
    function automatic logic [7:0] status_of(input scp_regs_t s,
        input logic [1:0] c, input logic [3:0] ir, input logic [3:0] du,
        input logic [3:0] oc, input logic ot);
        status_of = chan_status(s, c, ir[c], du[c], oc[c], ot);
    endfunction : status_of

    always_comb
    begin
        r_nxt = r_r;
        r_nxt.sclkPrev = sclkS;
        r_nxt.start = 1'b0;
        r_nxt.odLvl = 1'b0;
        fall = r_r.sclkPrev & ~sclkS; // [RQ1]
        word = {r_r.shreg[14:0], dinS}; // [RQ4]
        hit8 = addr_hit(word[7:0], bankS, DEVICE_CODE); // [RQ7] [RQ9]
        hitW = addr_hit(word[15:8], bankS, DEVICE_CODE); // [RQ5]
        wc = word[CH_LSB+1:CH_LSB]; // [RQ8] [RQ18]
        d = word[7:0];
        wrExec = 1'b0;
        initNow = 1'b0;

        // Countdown models the noise filter lag on ready
        for (int i = 0; i < NCH; i++)
        begin
            if (r_r.settle[i] != 16'h0000)
            begin
                r_nxt.settle[i] = r_r.settle[i] - 16'h0001; // [RQ16]
            end
            r_nxt.ready[i] = (status_of(r_r, 2'(i), chanInReg,
                dutyExtreme, overCurrent, overTemp) == 8'h00); // [RQ14]
        end

        if (fsS)
        begin
            r_nxt.st = ST_WAIT; // [RQ3]
            r_nxt.bitCnt = 5'd0; // [RQ3]
            r_nxt.rdAct = 1'b0;
            r_nxt.odEn = 1'b0;
        end
        else
        begin
            unique case (r_r.st)
                ST_WAIT, ST_SHIFT:
                begin
                    if (fall)
                    begin
                        r_nxt.st = ST_SHIFT;
                        r_nxt.shreg = word; // [RQ4]
                        r_nxt.bitCnt = r_r.bitCnt + 5'd1;
                        if (r_r.bitCnt == 5'd7)
                        begin
                            // Read needs bit 15 set and a matching header
                            if (word[7] && hit8)
                            begin
                                r_nxt.rdAct = 1'b1; // [RQ6]
                                r_nxt.stat = status_of(r_r, word[5:4],
                                    chanInReg, dutyExtreme, overCurrent,
                                    overTemp); // [RQ14]
                                r_nxt.odEn = ~r_nxt.stat[7]; // [RQ22]
                            end
                            else
                            begin
                                r_nxt.rdAct = 1'b0; // [RQ23]
                                r_nxt.odEn = 1'b0;
                            end
                        end
                        else if (r_r.bitCnt == 5'd15)
                        begin
                            r_nxt.st = ST_DONE;
                            r_nxt.rdAct = 1'b0;
                            r_nxt.odEn = 1'b0; // [RQ22]
                            wrExec = ~word[BIT_RW] & hitW; // [RQ6] [RQ23]
                        end
                        else if (r_r.rdAct)
                        begin
                            r_nxt.stat = {r_r.stat[6:0], 1'b0};
                            r_nxt.odEn = ~r_r.stat[6]; // [RQ22]
                        end
                    end
                end
                ST_DONE:
                begin
                    r_nxt.odEn = 1'b0;
                end
                default:
                begin
                    r_nxt.st = ST_DONE;
                end
            endcase
        end

        if (wrExec)
        begin
            initNow = d[D_INIT] & d[D_QUAL] & ~r_r.initDone; // [RQ12]
            if (initNow)
            begin
                r_nxt.initDone = 1'b1; // [RQ12]
                r_nxt.en = RST_EN; // [RQ20]
                r_nxt.code = RST_CODE; // [RQ20]
                r_nxt.stagger = ~bankS; // [RQ20]
            end
            else if (d[D_SHUT])
            begin
                r_nxt.en[wc] = 1'b0; // [RQ10]
            end
            else if (d[D_GLOB])
            begin
                r_nxt.code = {NCH{d[7:V_LSB]}}; // [RQ11]
                r_nxt.en = 4'hf; // [RQ11]
                r_nxt.start = 1'b1;
                for (int i = 0; i < NCH; i++)
                begin
                    r_nxt.settle[i] = r_r.filt; // [RQ16]
                end
            end
            else
            begin
                r_nxt.code[wc*4+:4] = d[7:V_LSB]; // [RQ19]
                r_nxt.en[wc] = 1'b1;
                r_nxt.settle[wc] = r_r.filt; // [RQ16]
            end
        end

        for (int i = 0; i < NCH; i++)
        begin
            r_nxt.pass[i] = r_nxt.en[i] &
                (r_nxt.code[i*4+:4] == CODE_PASS); // [RQ13] [RQ19]
        end

        // Slave answers one cycle after the request, writes land at release
        if (r_r.waitReq && (avs_read || avs_write))
        begin
            r_nxt.waitReq = 1'b0;
            unique case (avs_address)
                OFF_STATE: r_nxt.rdata = {22'h0, r_r.stagger, r_r.initDone,
                    r_r.pass, r_r.en};
                OFF_CODE: r_nxt.rdata = {16'h0, r_r.code};
                OFF_READY: r_nxt.rdata = {28'h0, r_r.ready};
                OFF_FILT: r_nxt.rdata = {16'h0, r_r.filt};
                default: r_nxt.rdata = 32'h0;
            endcase
        end
        else
        begin
            r_nxt.waitReq = 1'b1;
            if (!r_r.waitReq && avs_write && avs_address == OFF_FILT)
            begin
                if (avs_byteenable[0])
                begin
                    r_nxt.filt[7:0] = avs_writedata[7:0];
                end
                if (avs_byteenable[1])
                begin
                    r_nxt.filt[15:8] = avs_writedata[15:8];
                end
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            r_r <= '0;
            r_r.st <= ST_DONE;
            r_r.filt <= SETTLE_CYCLES;
            r_r.waitReq <= 1'b1;
        end
        else
        begin
            r_r <= r_nxt;
        end
    end

    assign statusOut = r_r.odLvl;
    assign statusOutEn = r_r.odEn;
    assign chanEnable = r_r.en;
    assign chanCode = r_r.code;
    assign passThrough = r_r.pass;
    assign globalStart = r_r.start;
    assign initDone = r_r.initDone;
    assign rampStagger = r_r.stagger;
    assign avs_readdata = r_r.rdata;
    assign avs_waitrequest = r_r.waitReq;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_miss;
        !fsS && r_r.st == ST_SHIFT && fall && r_r.bitCnt == 5'd7 &&
            !(word[7] && hit8);
    endsequence
    sequence s_glob;
        wrExec && !initNow && !d[D_SHUT] && d[D_GLOB];
    endsequence

    property p_hold;
        fsS |=> (r_r.bitCnt == 5'd0 && r_r.st == ST_WAIT);
    endproperty
    a_hold: assert property (p_hold) else $error("counter not held"); // [RQ3]

    property p_first;
        (!fsS && r_r.st == ST_WAIT && fall) |=>
            (r_r.bitCnt == 5'd1 && r_r.shreg[0] == $past(dinS));
    endproperty
    a_first: assert property (p_first) else $error("first bit lost"); // [RQ4]

    property p_release;
        (r_r.st != ST_SHIFT) |-> !r_r.odEn;
    endproperty
    a_release: assert property (p_release) else $error("output driven"); // [RQ22]

    property p_miss;
        s_miss |=> (!r_r.odEn && !r_r.rdAct) until (r_r.st != ST_SHIFT);
    endproperty
    a_miss: assert property (p_miss) else $error("answered mismatch"); // [RQ23]

    property p_shut;
        (wrExec && !initNow && d[D_SHUT]) |=> !r_r.en[$past(wc)];
    endproperty
    a_shut: assert property (p_shut) else $error("channel not shut"); // [RQ10]

    property p_glob;
        s_glob |=> (r_r.en == 4'hf && r_r.start) ##1 !r_r.start;
    endproperty
    a_glob: assert property (p_glob) else $error("global start wrong"); // [RQ11]

    property p_once;
        r_r.initDone |=> r_r.initDone;
    endproperty
    a_once: assert property (p_once) else $error("init lock lost"); // [RQ12]

    property p_init;
        initNow |=> (r_r.code == 16'h0 && r_r.en == 4'h0);
    endproperty
    a_init: assert property (p_init) else $error("init did not clear"); // [RQ20]

    property p_hot;
        overTemp [*2] |-> (r_r.ready == 4'h0);
    endproperty
    a_hot: assert property (p_hot) else $error("ready under overtemp"); // [RQ15]

    property p_pass;
        r_r.pass[0] |-> (r_r.en[0] && chanCode[3:0] == CODE_PASS);
    endproperty
    a_pass: assert property (p_pass) else $error("bad pass-through"); // [RQ13]
endmodule : scp_port
`default_nettype wire

// [verilog/scp_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module scp_sync #(
    parameter int W = 4
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [W-1:0] async,
    output logic [W-1:0] stable
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } scp_sync_t;

    scp_sync_t r_r;
    scp_sync_t r_nxt;

    if (W < 1)
    begin : g_bad_width
        $error("scp_sync: width must be positive");
    end

    // Stage one feeds stage two only; a change counts when two and three agree
    always_comb
    begin
        r_nxt = r_r;
        r_nxt.s1 = async;
        r_nxt.s2 = r_r.s1;
        r_nxt.s3 = r_r.s2;
        for (int i = 0; i < W; i++)
        begin
            if (r_r.s2[i] == r_r.s3[i])
            begin
                r_nxt.q[i] = r_r.s3[i];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            r_r <= '0;
        end
        else
        begin
            r_r <= r_nxt;
        end
    end

    assign stable = r_r.q;
endmodule : scp_sync
`default_nettype wire
